/* File: dv/field_threshold_comparator_tb_top.sv */
// bench: controller and sensor joined over the link
`timescale 1ns/1ns
`include "fth_map.svh"
module field_threshold_comparator_tb_top;
    import fth_pkg::*;
    logic clock = 1'b0;
    logic core_clock = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic req_write = 1'b0;
    addr_t req_addr = 8'h00;
    word_t req_data = 16'h0000;
    logic raw_valid = 1'b0;
    word_t raw_field = 16'h0000;
    word_t nv_hys = 16'h0007;
    logic nv_load = 1'b0;
    word_t nv_seen = 16'h0000;
    logic busy;
    logic done;
    logic nv_store;
    logic threshold_out;
    word_t rd_word;
    word_t nv_data1;
    int n_errors = 0;
    int total_checks = 0;
    addr_t rd_a[10] = '{`RD_TEMP, `RD_THR1, `RD_HYS1, `RD_THR2, `RD_HYS2, `RD_INV,
        `RD_OFFSET, `RD_FILT, `RD_MODE, 8'h20};
    word_t rd_e[10] = '{16'h0019, `DEF_THR1, `DEF_HYS1, `DEF_THR2, `DEF_HYS2, 16'h0000,
        `DEF_OFFSET, `DEF_FILT, 16'h0000, 16'h0000};

    fth_link_if link ();
    fth_controller fth_controller_inst (.clock, .rst, .link, .req, .req_write, .req_addr,
        .req_data, .busy, .done, .rd_word);
    fth_sensor fth_sensor_inst (.clock(core_clock), .rst, .link, .raw_valid, .raw_field,
        .temperature(16'h0019), .nv_first_hysteresis(nv_hys), .nv_second_hysteresis(nv_hys),
        .nv_load, .nv_store_data1(nv_data1), .nv_store_data2(), .nv_store, .threshold_out);
    fth_link_asserts fth_link_asserts_inst (.clock, .rst, .sclk(link.sclk),
        .ss_n(link.ss_n), .mosi(link.mosi));

    initial forever #5 clock = ~clock;
    initial
    begin
        #1;
        forever #3 core_clock = ~core_clock;
    end

    always @(posedge core_clock)
        if (nv_store === 1'b1)
            nv_seen <= nv_data1;

    task automatic check(input word_t act, input word_t exp);
        total_checks++;
        if (act !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, act, exp);
        end
    endtask : check

    task automatic check_out(input logic exp);
        check({15'h0000, threshold_out}, {15'h0000, exp});
    endtask : check_out

    task automatic frame(input logic wr, input addr_t a, input word_t d);
        int i;
        @(negedge clock);
        req = 1'b1;
        req_write = wr;
        req_addr = a;
        req_data = d;
        @(negedge clock);
        req = 1'b0;
        check({15'h0000, busy}, 16'h0001);
        for (i = 0; i < 400 && done !== 1'b1; i++)
            @(negedge clock);
        check({15'h0000, done}, 16'h0001);
        repeat (4) @(negedge clock);
    endtask : frame

    task automatic rd_check(input addr_t a, input word_t exp);
        frame(1'b0, a, 16'h0000);
        frame(1'b0, a, 16'h0000);
        check(rd_word, exp);
    endtask : rd_check

    task automatic feed(input word_t v, input logic exp);
        @(negedge core_clock);
        raw_field = v;
        raw_valid = 1'b1;
        @(negedge core_clock);
        raw_valid = 1'b0;
        repeat (12) @(negedge core_clock);
        check_out(exp);
    endtask : feed

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        #400000;
        n_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        foreach (rd_a[i])
            rd_check(rd_a[i], rd_e[i]);
        $display("defaults test done");
        feed(16'h0096, 1'b1);
        feed(16'h005f, 1'b1);
        feed(16'h0050, 1'b0);
        feed(16'hff6a, 1'b1);
        rd_check(`RD_SENSOR, 16'hff6a);
        rd_check(`RD_TOUT, 16'h0001);
        feed(16'hffce, 1'b0);
        $display("omnipolar test done");
        frame(1'b1, `WR_OFFSET, 16'h003c);
        feed(16'h0032, 1'b1);
        rd_check(`RD_OFFSET, 16'h003c);
        frame(1'b1, `WR_INV, 16'h0001);
        feed(16'hffc4, 1'b1);
        frame(1'b1, `WR_INV, 16'h0000);
        $display("offset and invert test done");
        frame(1'b1, `WR_THR1, 16'h0032);
        rd_check(`RD_THR1, 16'h0032);
        frame(1'b1, `WR_FACTORY, 16'h0000);
        rd_check(`RD_THR1, `DEF_THR1);
        rd_check(`RD_OFFSET, `DEF_OFFSET);
        $display("factory reset test done");
        frame(1'b1, `WR_MODE, 16'h0001);
        feed(16'h0096, 1'b0);
        feed(16'hff6a, 1'b1);
        feed(16'hffa1, 1'b1);
        feed(16'hffce, 1'b0);
        $display("unipolar test done");
        frame(1'b1, `WR_MODE, 16'h0002);
        frame(1'b1, `WR_HYS1, 16'h0096);
        feed(16'hff6a, 1'b1);
        feed(16'h0000, 1'b1);
        feed(16'h003c, 1'b0);
        check(nv_seen, 16'h0096);
        @(negedge core_clock);
        nv_load = 1'b1;
        @(negedge core_clock);
        nv_load = 1'b0;
        rd_check(`RD_HYS1, 16'h0007);
        rd_check(`RD_HYS2, 16'h0007);
        $display("bipolar and storage test done");
        frame(1'b1, `WR_MODE, 16'h0000);
        frame(1'b1, `WR_FILT, 16'h0004);
        rd_check(`RD_FILT, 16'h0004);
        repeat (20) feed(16'h0000, 1'b0);
        feed(16'h00c8, 1'b0);
        feed(16'h00c8, 1'b0);
        feed(16'h00c8, 1'b1);
        $display("filter test done");
        end_of_test();
    end
endmodule : field_threshold_comparator_tb_top

/* File: dv/fth_link_asserts.sv */
// link checker: frame length, padding, idle levels and clock timing
`timescale 1ns/1ns
module fth_link_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // resolved link wires
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi
);
    logic sclk_q;
    logic [5:0] edges;
    logic [8:0] span;
    logic [31:0] bits;
    wire rise = sclk && !sclk_q && !ss_n;

    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clock or posedge rst)
        if (rst)
            sclk_q <= 1'b1;
        else
            sclk_q <= sclk;

    always_ff @(posedge clock or posedge rst)
        if (rst)
            edges <= 6'h00;
        else if (ss_n)
            edges <= 6'h00;
        else if (rise)
            edges <= edges + 6'h01;

    always_ff @(posedge clock or posedge rst)
        if (rst)
            span <= 9'h000;
        else if (ss_n)
            span <= 9'h000;
        else
            span <= span + 9'h001;

    always_ff @(posedge clock or posedge rst)
        if (rst)
            bits <= 32'h0;
        else if (rise)
            bits <= {bits[30:0], mosi};

    sequence clock_half;
        $stable(sclk) [*3];
    endsequence
    sequence select_idle;
        ss_n [*3];
    endsequence

    a_frame_bit_count: assert property ($rose(ss_n) |-> edges == 6'h20)
        else $error("frame without 32 clock edges");
    a_pad_bits_zero: assert property ($rose(ss_n) |-> bits[22:16] == 7'h00)
        else $error("pad bits not zero");
    a_write_addr_range: assert property ($rose(ss_n) && bits[23] |-> bits[31:24] >= 8'h30)
        else $error("write flag on a read address");
    a_read_addr_range: assert property ($rose(ss_n) && !bits[23] |-> bits[31:24] < 8'h30)
        else $error("read frame on a write address");
    a_clock_idle_high: assert property (ss_n && $past(ss_n) |-> sclk && $stable(sclk))
        else $error("link clock moves outside a frame");
    a_sclk_half_period: assert property (!ss_n && $changed(sclk) |=> clock_half)
        else $error("link clock half period too short");
    a_frame_span: assert property ($rose(ss_n) |-> span inside {[9'd248:9'd272]})
        else $error("select low for wrong number of cycles");
    a_select_gap: assert property ($rose(ss_n) |=> select_idle)
        else $error("select idle gap too short");
    a_select_edge_high: assert property ($fell(ss_n) |-> sclk)
        else $error("link clock low when select falls");
    a_mosi_settled: assert property (rise |-> $stable(mosi))
        else $error("data line moves at sampling edge");
endmodule : fth_link_asserts

/* File: src/fth_comparator.sv */
// threshold comparator with hysteresis for one corrected sample stream
`timescale 1ns/1ns
module fth_comparator (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // sample and settings
    input wire logic sample_valid,
    input wire fth_pkg::word_t sample,
    input wire fth_pkg::polarity_mode_e mode,
    input wire fth_pkg::word_t first_threshold,
    input wire fth_pkg::word_t first_hysteresis,
    input wire fth_pkg::word_t second_threshold,
    input wire fth_pkg::word_t second_hysteresis,
    // comparator state
    output logic state
);
    import fth_pkg::*;
    logic signed [17:0] x;
    logic signed [17:0] t1;
    logic signed [17:0] t2;
    logic signed [17:0] off1;
    logic signed [17:0] off2;
    logic dir1;
    logic on_cond;
    logic off_cond;
    always_comb
    begin
        x = 18'(sample);
        t1 = 18'(first_threshold);
        t2 = 18'(second_threshold);
        dir1 = first_threshold[15];
        // turn-off point is threshold minus hysteresis toward zero
        off1 = dir1 ? t1 + 18'(first_hysteresis) : t1 - 18'(first_hysteresis);
        off2 = second_threshold[15] ? t2 + 18'(second_hysteresis)
                                    : t2 - 18'(second_hysteresis);
        on_cond = 1'b0;
        off_cond = 1'b0;
        case (mode)
            unipolar:
            begin
                on_cond = dir1 ? (x <= t1) : (x >= t1);
                off_cond = dir1 ? (x > off1) : (x < off1);
            end
            bipolar:
            begin
                on_cond = dir1 ? (x <= t1) : (x >= t1);
                off_cond = dir1 ? (x > off1) : (x < off1);
            end
            default:
            begin
                on_cond = (x <= t1 && dir1) || (x >= t2 && !second_threshold[15]);
                off_cond = (dir1 ? x > off1 : x < off1) && (x < off2);
            end
        endcase
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            state <= 1'b0;
        else if (sample_valid)
        begin
            if (!state && on_cond)
                state <= 1'b1;
            else if (state && off_cond)
                state <= 1'b0;
            // otherwise held between the two points
        end
    end
endmodule : fth_comparator

/* File: src/fth_controller.sv */
// controller end: spi master issuing register reads and writes
`timescale 1ns/1ns
`include "fth_map.svh"
module fth_controller (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    fth_link_if.controller link,
    // request and answer
    input wire logic req,
    input wire logic req_write,
    input wire fth_pkg::addr_t req_addr,
    input wire fth_pkg::word_t req_data,
    output logic busy,
    output logic done,
    output fth_pkg::word_t rd_word
);
    import fth_pkg::*;
    logic [31:0] sh;
    logic [15:0] rx;
    logic [5:0] bits;
    logic [2:0] div;
    logic [1:0] miso_s;
    logic sclk_q, ss_q;
    word_t wr_data;
    // filter constant forced into its legal range
    always_comb
    begin
        wr_data = req_data;
        if (req_write && req_addr == `WR_FILT)
        begin
            if (req_data < 16'sh0001)
                wr_data = {9'h000, `FILT_MIN};
            else if (req_data > 16'sh007f)
                wr_data = {9'h000, `FILT_MAX};
        end
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            miso_s <= 2'h0;
        else
            miso_s <= {miso_s[0], link.miso};
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sh <= 32'h0;
            rx <= 16'h0;
            bits <= 6'h0;
            div <= 3'h0;
            sclk_q <= 1'b1;
            ss_q <= 1'b1;
            busy <= 1'b0;
            done <= 1'b0;
            rd_word <= 16'h0;
        end
        else
        begin
            done <= 1'b0;
            if (!busy && req)
            begin
                sh <= {req_addr, req_write, 7'h0, wr_data};
                busy <= 1'b1;
                ss_q <= 1'b0;
                bits <= 6'h0;
                div <= 3'h0;
            end
            else if (busy)
            begin
                div <= (div == 3'(`SCLK_DIV - 1)) ? 3'h0 : div + 3'h1;
                if (div == 3'(`SCLK_DIV - 1))
                begin
                    if (bits == 6'(`FRAME_BITS))
                    begin
                        // select rises half a period after the last rising edge
                        busy <= 1'b0;
                        ss_q <= 1'b1;
                        done <= 1'b1;
                        rd_word <= rx;
                    end
                    else if (sclk_q)
                    begin
                        // falling edge: next bit out, first bit already on the line
                        sclk_q <= 1'b0;
                        if (bits != 6'h0)
                            sh <= {sh[30:0], 1'b0};
                    end
                    else
                    begin
                        sclk_q <= 1'b1;
                        rx <= {rx[14:0], miso_s[1]};
                        bits <= bits + 6'h1;
                    end
                end
            end
        end
    end
    assign link.sclk_o = sclk_q;
    assign link.sclk_oe = ~sclk_q;
    assign link.ss_o = ss_q;
    assign link.ss_oe = ~ss_q;
    assign link.mosi_o = sh[31];
    assign link.mosi_oe = busy & ~sh[31];
endmodule : fth_controller

/* File: src/fth_link_if.sv */
// spi link between controller and sensor; sclk, ss_n and mosi are open-drain wired lines, miso is driven directly
`timescale 1ns/1ns
interface fth_link_if;
    logic sclk_o;
    logic sclk_oe;
    logic ss_o;
    logic ss_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso;
    wire sclk = sclk_oe ? sclk_o : 1'b1;
    wire ss_n = ss_oe ? ss_o : 1'b1;
    wire mosi = mosi_oe ? mosi_o : 1'b1;
    modport controller (output sclk_o, sclk_oe, ss_o, ss_oe, mosi_o, mosi_oe, input miso);
    modport sensor (input sclk, ss_n, mosi, output miso);
endinterface : fth_link_if

/* File: src/fth_map.svh */
// register map, reset values and field layout of the threshold comparator
`ifndef FTH_MAP_SVH
`define FTH_MAP_SVH
`define RD_SENSOR 8'h00
`define RD_TEMP 8'h01
`define RD_TOUT 8'h02
`define RD_THR1 8'h10
`define RD_HYS1 8'h11
`define RD_THR2 8'h12
`define RD_HYS2 8'h13
`define RD_INV 8'h14
`define RD_OFFSET 8'h15
`define RD_FILT 8'h16
`define RD_MODE 8'h17
`define WR_THR1 8'h30
`define WR_HYS1 8'h31
`define WR_THR2 8'h32
`define WR_HYS2 8'h33
`define WR_INV 8'h34
`define WR_OFFSET 8'h35
`define WR_FILT 8'h36
`define WR_MODE 8'h37
`define WR_FACTORY 8'h38
`define WR_FLAG_BIT 23
`define DEF_THR1 16'hff9c
`define DEF_HYS1 16'h000a
`define DEF_THR2 16'h0064
`define DEF_HYS2 16'h000a
`define DEF_OFFSET 16'h0000
`define DEF_FILT 16'h0001
`define DEF_TEMP 16'h0019
`define FILT_MIN 7'h01
`define FILT_MAX 7'h7f
`define FRAME_BITS 32
`define SCLK_DIV 4
`endif

/* File: src/fth_pkg.sv */
// types shared by both ends of the threshold comparator link
package fth_pkg;
    typedef enum logic [1:0] {omnipolar, unipolar, bipolar} polarity_mode_e;
    typedef logic signed [15:0] word_t;
    typedef logic [7:0] addr_t;
endpackage : fth_pkg

/* File: src/fth_sensor.sv */
// sensor end: spi slave, parameter store, offset, filter and comparator
`timescale 1ns/1ns
`include "fth_map.svh"
module fth_sensor (
    // core clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    fth_link_if.sensor link,
    // measurement input
    input wire logic raw_valid,
    input wire fth_pkg::word_t raw_field,
    input wire fth_pkg::word_t temperature,
    // nonvolatile hysteresis copies
    input wire fth_pkg::word_t nv_first_hysteresis,
    input wire fth_pkg::word_t nv_second_hysteresis,
    input wire logic nv_load,
    output fth_pkg::word_t nv_store_data1,
    output fth_pkg::word_t nv_store_data2,
    output logic nv_store,
    // threshold output
    output logic threshold_out
);
    import fth_pkg::*;
    // link domain, clocked by the link clock
    logic [5:0] bit_cnt;
    logic [31:0] shift_in;
    logic [15:0] shift_out;
    logic miso_q;
    logic frame_tgl;
    logic [31:0] frame_word;
    word_t rd_hold;
    logic [2:0] rd_tgl_sync;
    always_ff @(posedge link.sclk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt <= 6'h00;
            shift_in <= 32'h0;
            frame_tgl <= 1'b0;
            frame_word <= 32'h0;
        end
        else if (link.ss_n)
            bit_cnt <= 6'h00;
        else
        begin
            shift_in <= {shift_in[30:0], link.mosi};
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == 6'(`FRAME_BITS - 1))
            begin
                frame_word <= {shift_in[30:0], link.mosi};
                frame_tgl <= ~frame_tgl;
                bit_cnt <= 6'h00;
            end
        end
    end
    // read data leaves msb first in the second half of the frame
    always_ff @(negedge link.sclk or posedge rst)
    begin
        if (rst)
        begin
            shift_out <= 16'h0;
            miso_q <= 1'b0;
        end
        else if (bit_cnt == 6'h10)
        begin
            shift_out <= {rd_hold[14:0], 1'b0};
            miso_q <= rd_hold[15];
        end
        else
        begin
            shift_out <= {shift_out[14:0], 1'b0};
            miso_q <= shift_out[15];
        end
    end
    assign link.miso = miso_q;
    // core domain
    logic [2:0] tgl_sync;
    logic [31:0] cmd;
    logic cmd_valid;
    word_t thr1, hys1, thr2, hys2, offset, filt;
    logic invert;
    polarity_mode_e mode;
    word_t corrected, filtered, rd_data;
    logic signed [23:0] acc;
    logic filt_valid, comp_state;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tgl_sync <= 3'h0;
        else
            tgl_sync <= {tgl_sync[1:0], frame_tgl};
    end
    // frame word is stable for many core cycles after its toggle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cmd <= 32'h0;
            cmd_valid <= 1'b0;
        end
        else
        begin
            cmd_valid <= tgl_sync[2] ^ tgl_sync[1];
            if (tgl_sync[2] ^ tgl_sync[1])
                cmd <= frame_word;
        end
    end
    function automatic word_t read_reg(input addr_t a);
        case (a)
            `RD_SENSOR: read_reg = filtered;
            `RD_TEMP: read_reg = temperature;
            `RD_TOUT: read_reg = {15'h0, threshold_out};
            `RD_THR1: read_reg = thr1;
            `RD_HYS1: read_reg = hys1;
            `RD_THR2: read_reg = thr2;
            `RD_HYS2: read_reg = hys2;
            `RD_INV: read_reg = {15'h0, invert};
            `RD_OFFSET: read_reg = offset;
            `RD_FILT: read_reg = filt;
            `RD_MODE: read_reg = {14'h0, mode};
            default: read_reg = 16'h0000;
        endcase
    endfunction : read_reg
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rd_data <= 16'h0;
        else if (cmd_valid)
            rd_data <= read_reg(cmd[31:24]);
    end
    // read word carried in the next frame; stable while link idles between frames
    always_ff @(posedge link.sclk or posedge rst)
    begin
        if (rst)
            rd_hold <= 16'h0;
        else if (bit_cnt == 6'h00)
            rd_hold <= rd_data;
    end
    logic wr;
    assign wr = cmd_valid && cmd[`WR_FLAG_BIT];
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            thr1 <= `DEF_THR1;
            thr2 <= `DEF_THR2;
            offset <= `DEF_OFFSET;
            filt <= `DEF_FILT;
            invert <= 1'b0;
            mode <= omnipolar;
        end
        else if (wr && cmd[31:24] == `WR_FACTORY)
        begin
            thr1 <= `DEF_THR1;
            thr2 <= `DEF_THR2;
            offset <= `DEF_OFFSET;
            filt <= `DEF_FILT;
        end
        else if (wr)
        begin
            case (cmd[31:24])
                `WR_THR1: thr1 <= cmd[15:0];
                `WR_THR2: thr2 <= cmd[15:0];
                `WR_INV: invert <= cmd[0];
                `WR_OFFSET: offset <= cmd[15:0];
                `WR_FILT: filt <= cmd[15:0];
                `WR_MODE: mode <= polarity_mode_e'(cmd[1:0]);
                default: ;
            endcase
        end
    end
    // hysteresis mirrors the nonvolatile store and writes through to it
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            hys1 <= `DEF_HYS1;
            hys2 <= `DEF_HYS2;
            nv_store <= 1'b0;
        end
        else
        begin
            nv_store <= wr && (cmd[31:24] == `WR_HYS1 || cmd[31:24] == `WR_HYS2);
            if (nv_load)
            begin
                hys1 <= nv_first_hysteresis;
                hys2 <= nv_second_hysteresis;
            end
            else if (wr && cmd[31:24] == `WR_HYS1)
                hys1 <= cmd[15:0];
            else if (wr && cmd[31:24] == `WR_HYS2)
                hys2 <= cmd[15:0];
        end
    end
    assign nv_store_data1 = hys1;
    assign nv_store_data2 = hys2;
    assign corrected = raw_field + offset;
    // exponential filter, weight 1/filt; filt of one passes samples through
    logic signed [25:0] diff;
    always_comb
    begin
        diff = 26'(corrected) - 26'(acc >>> 7);
        diff = (diff * 26'sd128) / 26'($signed({1'b0, filt[6:0]}));
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            acc <= 24'h0;
            filt_valid <= 1'b0;
        end
        else
        begin
            filt_valid <= raw_valid;
            if (raw_valid && filt[6:0] <= `FILT_MIN)
                acc <= 24'(corrected) <<< 7;
            else if (raw_valid)
                acc <= acc + diff[23:0];
        end
    end
    assign filtered = acc[22:7];
    fth_comparator u_cmp (
        .clock(clock),
        .rst(rst),
        .sample_valid(filt_valid),
        .sample(filtered),
        .mode(mode),
        .first_threshold(thr1),
        .first_hysteresis(hys1),
        .second_threshold(thr2),
        .second_hysteresis(hys2),
        .state(comp_state)
    );
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            threshold_out <= 1'b0;
        else
            threshold_out <= comp_state ^ invert;
    end
endmodule : fth_sensor
